// *** rtl/atr_field_reg.sv ***
`timescale 1ns/10ps
module atr_field_reg
	import atr_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wrEn,
	input wire logic [W-1:0] wrData,
	output logic [W-1:0] q
);
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	assign q_nxt = wrEn ? wrData : q_r;
	assign q = q_r;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			q_r <= RST; // [RULE16]
		end else begin
			q_r <= q_nxt; // [RULE16]
		end
	end
endmodule

// *** rtl/atr_pkg.sv ***
package atr_pkg;
	localparam logic [7:0] ATR_OFS_OSC_BIAS = 8'h18;
	localparam logic [7:0] ATR_OFS_RSVD_A = 8'h19;
	localparam logic [7:0] ATR_OFS_REF_TRIM = 8'h1A;
	localparam logic [7:0] ATR_OFS_RSVD_B = 8'h1B;
	localparam logic [7:0] ATR_OFS_PLL_CTRL = 8'h1C;
	localparam logic [7:0] ATR_OFS_PLL_CUR = 8'h1D;
	localparam logic [7:0] ATR_OFS_PLL_DET = 8'h1E;
	localparam logic [7:0] ATR_OFS_REG_SHORT = 8'h1F;
	localparam logic [7:0] ATR_OFS_UV_TEST = 8'h20;
	localparam logic [7:0] ATR_OFS_LINE_TEST = 8'h21;
	localparam logic [7:0] ATR_OFS_PWR_OVR_A = 8'h22;

	localparam int ATR_POS_OSC_BIAS = 0;
	localparam int ATR_W_OSC_BIAS = 3;
	localparam int ATR_POS_BANDGAP = 4;
	localparam int ATR_W_BANDGAP = 4;
	localparam int ATR_POS_COMMON_V = 0;
	localparam int ATR_W_COMMON_V = 4;
	localparam int ATR_POS_PLL_DIV_RST = 4;
	localparam int ATR_POS_PLL_CUR_TEST = 1;
	localparam int ATR_POS_PLL_FREERUN = 0;
	localparam int ATR_POS_PLL_DET_PD = 0;
	localparam int ATR_POS_REG_OK = 4;
	localparam int ATR_POS_REG_AUTO_DIS = 0;
	localparam int ATR_POS_UV_THRESH = 1;
	localparam int ATR_POS_UV_REF = 0;
	localparam int ATR_POS_LOAD_0 = 3;
	localparam int ATR_POS_LOAD_1 = 2;
	localparam int ATR_POS_SLEW_0 = 1;
	localparam int ATR_POS_SLEW_1 = 0;
	localparam int ATR_POS_OVR = 0;
	localparam int ATR_W_OVR = 6;

	localparam logic [2:0] ATR_RST_OSC_BIAS = 3'h4;
	localparam logic [3:0] ATR_RST_BANDGAP = 4'h4;
	localparam logic [3:0] ATR_RST_COMMON_V = 4'h0;
	localparam logic [0:0] ATR_RST_PLL_DIV_RST = 1'h1;
	localparam logic [0:0] ATR_RST_BIT_CLR = 1'h0;
	localparam logic [0:0] ATR_RST_BIT_SET = 1'h1;
	localparam logic [7:0] ATR_RST_PLL_CUR = 8'h00;
	localparam logic [5:0] ATR_RST_OVR = 6'h00;
endpackage

// *** rtl/atr_short_monitor.sv ***
`timescale 1ns/10ps
module atr_short_monitor
	import atr_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ldoShortDet,
	input wire logic autoOffDisable,
	output logic regulatorOk,
	output logic ldoPowerDown
);
	logic regulatorOk_r;
	logic ldoPowerDown_r;
	logic regulatorOk_nxt;
	logic ldoPowerDown_nxt;

	// flag is a live status; low for as long as the short is seen
	assign regulatorOk_nxt = ~ldoShortDet; // [RULE6]
	// auto power-down only follows a short when software has not disabled it
	assign ldoPowerDown_nxt = ldoShortDet & ~autoOffDisable; // [RULE7]
	assign regulatorOk = regulatorOk_r;
	assign ldoPowerDown = ldoPowerDown_r;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			regulatorOk_r <= ATR_RST_BIT_SET;
			ldoPowerDown_r <= ATR_RST_BIT_CLR;
		end else begin
			regulatorOk_r <= regulatorOk_nxt;
			ldoPowerDown_r <= ldoPowerDown_nxt;
		end
	end
endmodule

// *** rtl/atr_trim_test_regs.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: pll divider reset bit, low holds dividers
// RULE2: pll bit 1 enables reference-current test mode
// RULE3: pll bit 0 raises free-running frequency
// RULE4: test current code applies only in test
// RULE5: detector bit 0 powers down phase detector
// RULE6: regulator flag reads zero during short
// RULE7: auto power-down on short unless disabled
// RULE8: uv bit 1 selects threshold pair
// RULE9: uv bit 0 selects detection reference
// RULE10: line bits 3,2 first-stage load legs
// RULE11: line bits 1,0 slew, reset set
// RULE12: oscillator bias trim bits 2-0, reset 4
// RULE13: upper nibble bandgap trim, reset bit6
// RULE14: low nibble common voltage trim, reset 0
// RULE15: six override bits for analog sub-blocks
// RULE16: fields read back, reset, reserved zero
module atr_trim_test_regs
	import atr_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	input wire logic ldoShortDet,
	output logic [2:0] oscBiasTrim,
	output logic [3:0] bandgapTrim,
	output logic [3:0] commonVoltageTrim,
	output logic pllDividerReset_n,
	output logic pllCurrentTestEn,
	output logic pllFastFreerun,
	output logic [7:0] pllTestCurrentCode,
	output logic pllDetectorPowerdown,
	output logic regulatorOk,
	output logic regulatorAutoOffDisable,
	output logic ldoPowerDown,
	output logic uvThresholdSelect,
	output logic uvReferenceSelect,
	output logic lineLoadCtrl0,
	output logic lineLoadCtrl1,
	output logic lineSlewCtrl0,
	output logic lineSlewCtrl1,
	output logic [5:0] powerOverride
);
	logic selOsc;
	logic selRef;
	logic selPll;
	logic selCur;
	logic selDet;
	logic selShort;
	logic selUv;
	logic selLine;
	logic selOvr;
	logic wrOsc;
	logic wrRef;
	logic wrPll;
	logic wrCur;
	logic wrDet;
	logic wrShort;
	logic wrUv;
	logic wrLine;
	logic wrOvr;
	logic [7:0] pllCodeStored;
	logic [7:0] rdOsc;
	logic [7:0] rdRef;
	logic [7:0] rdPll;
	logic [7:0] rdDet;
	logic [7:0] rdShort;
	logic [7:0] rdUv;
	logic [7:0] rdLine;
	logic [7:0] rdOvr;
	logic [7:0] rdMux;
	logic [7:0] regRdData_r;
	logic [7:0] regRdData_nxt;
	logic anySel;
	logic [35:0] storedFields;

	assign selOsc = regAddr == ATR_OFS_OSC_BIAS;
	assign selRef = regAddr == ATR_OFS_REF_TRIM;
	assign selPll = regAddr == ATR_OFS_PLL_CTRL;
	assign selCur = regAddr == ATR_OFS_PLL_CUR;
	assign selDet = regAddr == ATR_OFS_PLL_DET;
	assign selShort = regAddr == ATR_OFS_REG_SHORT;
	assign selUv = regAddr == ATR_OFS_UV_TEST;
	assign selLine = regAddr == ATR_OFS_LINE_TEST;
	assign selOvr = regAddr == ATR_OFS_PWR_OVR_A;
	assign wrOsc = regWrEn & selOsc;
	assign wrRef = regWrEn & selRef;
	assign wrPll = regWrEn & selPll;
	assign wrCur = regWrEn & selCur;
	assign wrDet = regWrEn & selDet;
	assign wrShort = regWrEn & selShort;
	assign wrUv = regWrEn & selUv;
	assign wrLine = regWrEn & selLine;
	assign wrOvr = regWrEn & selOvr;

	atr_field_reg #(.W(ATR_W_OSC_BIAS), .RST(ATR_RST_OSC_BIAS)) oscBiasReg ( // [RULE12]
		.clock(clock), .rst_n(rst_n), .wrEn(wrOsc),
		.wrData(regWrData[ATR_POS_OSC_BIAS +: ATR_W_OSC_BIAS]), .q(oscBiasTrim));
	atr_field_reg #(.W(ATR_W_BANDGAP), .RST(ATR_RST_BANDGAP)) bandgapReg ( // [RULE13]
		.clock(clock), .rst_n(rst_n), .wrEn(wrRef),
		.wrData(regWrData[ATR_POS_BANDGAP +: ATR_W_BANDGAP]), .q(bandgapTrim));
	atr_field_reg #(.W(ATR_W_COMMON_V), .RST(ATR_RST_COMMON_V)) commonVReg ( // [RULE14]
		.clock(clock), .rst_n(rst_n), .wrEn(wrRef),
		.wrData(regWrData[ATR_POS_COMMON_V +: ATR_W_COMMON_V]), .q(commonVoltageTrim));
	atr_field_reg #(.W(1), .RST(ATR_RST_PLL_DIV_RST)) pllDivReg ( // [RULE1]
		.clock(clock), .rst_n(rst_n), .wrEn(wrPll),
		.wrData(regWrData[ATR_POS_PLL_DIV_RST]), .q(pllDividerReset_n));
	atr_field_reg #(.W(1), .RST(ATR_RST_BIT_CLR)) pllTestReg ( // [RULE2]
		.clock(clock), .rst_n(rst_n), .wrEn(wrPll),
		.wrData(regWrData[ATR_POS_PLL_CUR_TEST]), .q(pllCurrentTestEn));
	atr_field_reg #(.W(1), .RST(ATR_RST_BIT_CLR)) pllFreeReg ( // [RULE3]
		.clock(clock), .rst_n(rst_n), .wrEn(wrPll),
		.wrData(regWrData[ATR_POS_PLL_FREERUN]), .q(pllFastFreerun));
	atr_field_reg #(.W(8), .RST(ATR_RST_PLL_CUR)) pllCurReg ( // [RULE4]
		.clock(clock), .rst_n(rst_n), .wrEn(wrCur),
		.wrData(regWrData), .q(pllCodeStored));
	atr_field_reg #(.W(1), .RST(ATR_RST_BIT_CLR)) pllDetReg ( // [RULE5]
		.clock(clock), .rst_n(rst_n), .wrEn(wrDet),
		.wrData(regWrData[ATR_POS_PLL_DET_PD]), .q(pllDetectorPowerdown));
	atr_field_reg #(.W(1), .RST(ATR_RST_BIT_CLR)) autoOffReg ( // [RULE7]
		.clock(clock), .rst_n(rst_n), .wrEn(wrShort),
		.wrData(regWrData[ATR_POS_REG_AUTO_DIS]), .q(regulatorAutoOffDisable));
	atr_field_reg #(.W(1), .RST(ATR_RST_BIT_CLR)) uvThreshReg ( // [RULE8]
		.clock(clock), .rst_n(rst_n), .wrEn(wrUv),
		.wrData(regWrData[ATR_POS_UV_THRESH]), .q(uvThresholdSelect));
	atr_field_reg #(.W(1), .RST(ATR_RST_BIT_CLR)) uvRefReg ( // [RULE9]
		.clock(clock), .rst_n(rst_n), .wrEn(wrUv),
		.wrData(regWrData[ATR_POS_UV_REF]), .q(uvReferenceSelect));
	atr_field_reg #(.W(1), .RST(ATR_RST_BIT_CLR)) load0Reg ( // [RULE10]
		.clock(clock), .rst_n(rst_n), .wrEn(wrLine),
		.wrData(regWrData[ATR_POS_LOAD_0]), .q(lineLoadCtrl0));
	atr_field_reg #(.W(1), .RST(ATR_RST_BIT_CLR)) load1Reg ( // [RULE10]
		.clock(clock), .rst_n(rst_n), .wrEn(wrLine),
		.wrData(regWrData[ATR_POS_LOAD_1]), .q(lineLoadCtrl1));
	atr_field_reg #(.W(1), .RST(ATR_RST_BIT_SET)) slew0Reg ( // [RULE11]
		.clock(clock), .rst_n(rst_n), .wrEn(wrLine),
		.wrData(regWrData[ATR_POS_SLEW_0]), .q(lineSlewCtrl0));
	atr_field_reg #(.W(1), .RST(ATR_RST_BIT_SET)) slew1Reg ( // [RULE11]
		.clock(clock), .rst_n(rst_n), .wrEn(wrLine),
		.wrData(regWrData[ATR_POS_SLEW_1]), .q(lineSlewCtrl1));
	atr_field_reg #(.W(ATR_W_OVR), .RST(ATR_RST_OVR)) ovrReg ( // [RULE15]
		.clock(clock), .rst_n(rst_n), .wrEn(wrOvr),
		.wrData(regWrData[ATR_POS_OVR +: ATR_W_OVR]), .q(powerOverride));

	// flag input ignores writes; it is a live status, not storage
	atr_short_monitor shortMon (
		.clock(clock),
		.rst_n(rst_n),
		.ldoShortDet(ldoShortDet),
		.autoOffDisable(regulatorAutoOffDisable),
		.regulatorOk(regulatorOk),
		.ldoPowerDown(ldoPowerDown)
	);

	// gating keeps a stale test code off the pll in normal operation
	assign pllTestCurrentCode = pllCurrentTestEn ? pllCodeStored : 8'h00; // [RULE4]

	assign rdOsc = {5'h00, oscBiasTrim}; // [RULE16]
	assign rdRef = {bandgapTrim, commonVoltageTrim};
	assign rdPll = {3'h0, pllDividerReset_n, 2'h0, pllCurrentTestEn, pllFastFreerun};
	assign rdDet = {7'h00, pllDetectorPowerdown};
	assign rdShort = {3'h0, regulatorOk, 3'h0, regulatorAutoOffDisable}; // [RULE6]
	assign rdUv = {6'h00, uvThresholdSelect, uvReferenceSelect};
	assign rdLine = {4'h0, lineLoadCtrl0, lineLoadCtrl1, lineSlewCtrl0, lineSlewCtrl1};
	assign rdOvr = {2'h0, powerOverride};
	// reserved and unmapped offsets fall through to zero
	assign rdMux = selOsc ? rdOsc :
		selRef ? rdRef :
		selPll ? rdPll :
		selCur ? pllCodeStored :
		selDet ? rdDet :
		selShort ? rdShort :
		selUv ? rdUv :
		selLine ? rdLine :
		selOvr ? rdOvr : 8'h00; // [RULE16]
	assign regRdData_nxt = regRdEn ? rdMux : regRdData_r;
	assign regRdData = regRdData_r;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			regRdData_r <= 8'h00;
		end else begin
			regRdData_r <= regRdData_nxt;
		end
	end

	// assertion helpers only; nothing in the bank reads them
	assign anySel = selOsc | selRef | selPll | selCur | selDet | selShort | selUv | selLine
		| selOvr;
	assign storedFields = {oscBiasTrim, bandgapTrim, commonVoltageTrim, pllDividerReset_n,
		pllCurrentTestEn, pllFastFreerun, pllCodeStored, pllDetectorPowerdown,
		regulatorAutoOffDisable, uvThresholdSelect, uvReferenceSelect, lineLoadCtrl0,
		lineLoadCtrl1, lineSlewCtrl0, lineSlewCtrl1, powerOverride};

	property pWrite(logic wr, logic [7:0] mask, logic [7:0] rd);
		@(posedge clock) disable iff (!rst_n)
		wr |=> ((rd & mask) == ($past(regWrData) & mask));
	endproperty

	pll_div_rst_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
		wrPll |=> pllDividerReset_n == $past(regWrData[ATR_POS_PLL_DIV_RST]))
		else $error("pll divider reset bit did not take write");
	pll_reset_val_a: assert property (@(posedge clock) // [RULE1]
		!rst_n |=> pllDividerReset_n && !pllCurrentTestEn && !pllFastFreerun)
		else $error("pll control reset value wrong");
	pll_test_en_a: assert property (pWrite(wrPll, 8'h13, rdPll)) // [RULE2]
		else $error("pll control write not stored");
	pll_freerun_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
		!wrPll |=> $stable(pllFastFreerun))
		else $error("free-run bit changed without write");
	test_code_gate_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
		!pllCurrentTestEn |-> pllTestCurrentCode == 8'h00)
		else $error("test current reached pll outside test mode");
	test_code_pass_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
		wrCur ##1 pllCurrentTestEn |-> pllTestCurrentCode == $past(regWrData))
		else $error("test current code not applied");
	det_pd_write_a: assert property (pWrite(wrDet, 8'h01, rdDet)) // [RULE5]
		else $error("detector power-down bit wrong");
	short_flag_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
		ldoShortDet [*2] |-> !regulatorOk)
		else $error("regulator flag high during short");
	auto_off_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
		ldoShortDet && !regulatorAutoOffDisable |=> ldoPowerDown)
		else $error("regulator not powered down on short");
	auto_off_dis_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
		regulatorAutoOffDisable |=> !ldoPowerDown)
		else $error("regulator powered down while disabled");
	uv_select_a: assert property (pWrite(wrUv, 8'h03, rdUv)) // [RULE8]
		else $error("undervoltage select write not stored");
	uv_ref_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
		!wrUv |=> $stable(uvReferenceSelect))
		else $error("uv reference changed without write");
	line_write_a: assert property (pWrite(wrLine, 8'h0F, rdLine)) // [RULE10]
		else $error("line test write not stored");
	line_reset_a: assert property (@(posedge clock) // [RULE11]
		!rst_n |=> lineSlewCtrl0 && lineSlewCtrl1 && !lineLoadCtrl0 && !lineLoadCtrl1)
		else $error("line test reset value wrong");
	trim_reset_a: assert property (@(posedge clock) // [RULE12]
		!rst_n |=> oscBiasTrim == 3'h4 && bandgapTrim == 4'h4 && commonVoltageTrim == 4'h0)
		else $error("trim reset value wrong");
	ref_trim_write_a: assert property (pWrite(wrRef, 8'hFF, rdRef)) // [RULE13] [RULE14]
		else $error("reference trim write not stored");
	osc_trim_write_a: assert property (pWrite(wrOsc, 8'h07, rdOsc)) // [RULE12]
		else $error("oscillator trim write not stored");
	override_write_a: assert property (pWrite(wrOvr, 8'h3F, rdOvr)) // [RULE15]
		else $error("override write not stored");
	read_back_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE16]
		regRdEn && !selOsc && !selRef && !selPll && !selCur && !selDet && !selShort
		&& !selUv && !selLine && !selOvr |=> regRdData == 8'h00)
		else $error("reserved offset read nonzero");
	reserved_bits_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE16]
		regRdEn && selPll |=> (regRdData & 8'hEC) == 8'h00)
		else $error("reserved pll bits read nonzero");
	field_reset_a: assert property (@(posedge clock) // [RULE16] [RULE15]
		!rst_n |=> pllCodeStored == ATR_RST_PLL_CUR && powerOverride == ATR_RST_OVR
		&& !pllDetectorPowerdown && !regulatorAutoOffDisable && !uvThresholdSelect
		&& !uvReferenceSelect && regulatorOk && !ldoPowerDown && regRdData == 8'h00)
		else $error("field reset value wrong");
	field_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE16]
		!regWrEn |=> $stable(storedFields))
		else $error("field changed without write");
	refused_write_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE16]
		regWrEn && !anySel |=> $stable(storedFields))
		else $error("write to reserved offset changed a field");
	read_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE16]
		!regRdEn |=> $stable(regRdData))
		else $error("read data changed without read");
	osc_rsvd_read_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE16]
		regRdEn && selOsc |=> regRdData[7:3] == 5'h00)
		else $error("reserved oscillator bits read nonzero");
	ovr_rsvd_read_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE15]
		regRdEn && selOvr |=> regRdData[7:6] == 2'h0)
		else $error("reserved override bits read nonzero");
	short_rsvd_read_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE16]
		regRdEn && selShort |=> (regRdData & 8'hEE) == 8'h00)
		else $error("reserved regulator bits read nonzero");
	short_read_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
		regRdEn && selShort |=> regRdData[ATR_POS_REG_OK] == $past(regulatorOk))
		else $error("regulator flag not on read data");
	short_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
		!ldoShortDet |=> regulatorOk)
		else $error("regulator flag low without short");
	no_short_pd_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
		!ldoShortDet |=> !ldoPowerDown)
		else $error("regulator powered down without short");

	cover_short_off_c: cover property (@(posedge clock) disable iff (!rst_n)
		ldoShortDet && !regulatorAutoOffDisable ##1 ldoPowerDown);
	cover_test_mode_c: cover property (@(posedge clock) disable iff (!rst_n)
		wrCur ##[1:20] pllCurrentTestEn && pllTestCurrentCode != 8'h00);
	cover_div_reset_c: cover property (@(posedge clock) disable iff (!rst_n)
		!pllDividerReset_n ##[1:20] pllDividerReset_n);
	cover_readback_c: cover property (@(posedge clock) disable iff (!rst_n)
		wrOvr ##[1:4] (regRdEn && selOvr) ##1 regRdData != 8'h00);
	cover_refused_c: cover property (@(posedge clock) disable iff (!rst_n)
		regWrEn && !anySel);
endmodule

// *** testbench/atr_trim_test_regs_tb.sv ***
`timescale 1ns/10ps
module atr_trim_test_regs_tb
	import atr_pkg::*;
;
	logic clock, rst_n, regWrEn, regRdEn, ldoShortDet;
	logic [7:0] regAddr, regWrData, regRdData, pllTestCurrentCode, rdVal;
	logic [2:0] oscBiasTrim;
	logic [3:0] bandgapTrim, commonVoltageTrim;
	logic [5:0] powerOverride;
	logic pllDividerReset_n, pllCurrentTestEn, pllFastFreerun, pllDetectorPowerdown;
	logic regulatorOk, regulatorAutoOffDisable, ldoPowerDown, uvThresholdSelect;
	logic uvReferenceSelect, lineLoadCtrl0, lineLoadCtrl1, lineSlewCtrl0, lineSlewCtrl1;
	logic [37:0] outs;
	logic [23:0] rows [0:11];
	logic [7:0] rstVals [0:11];
	int badCount = 0;
	int compares = 0;

	// every field output packed so one compare covers the whole bank
	assign outs = {oscBiasTrim, bandgapTrim, commonVoltageTrim, pllDividerReset_n,
		pllCurrentTestEn, pllFastFreerun, pllTestCurrentCode, pllDetectorPowerdown,
		regulatorOk, regulatorAutoOffDisable, ldoPowerDown, uvThresholdSelect,
		uvReferenceSelect, lineLoadCtrl0, lineLoadCtrl1, lineSlewCtrl0, lineSlewCtrl1,
		powerOverride};

	atr_trim_test_regs dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.ldoShortDet(ldoShortDet), .oscBiasTrim(oscBiasTrim), .bandgapTrim(bandgapTrim),
		.commonVoltageTrim(commonVoltageTrim), .pllDividerReset_n(pllDividerReset_n),
		.pllCurrentTestEn(pllCurrentTestEn), .pllFastFreerun(pllFastFreerun),
		.pllTestCurrentCode(pllTestCurrentCode), .pllDetectorPowerdown(pllDetectorPowerdown),
		.regulatorOk(regulatorOk), .regulatorAutoOffDisable(regulatorAutoOffDisable),
		.ldoPowerDown(ldoPowerDown), .uvThresholdSelect(uvThresholdSelect),
		.uvReferenceSelect(uvReferenceSelect), .lineLoadCtrl0(lineLoadCtrl0),
		.lineLoadCtrl1(lineLoadCtrl1), .lineSlewCtrl0(lineSlewCtrl0),
		.lineSlewCtrl1(lineSlewCtrl1), .powerOverride(powerOverride));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic check(input string name, input logic [37:0] exp, input logic [37:0] got);
		compares++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			badCount++;
		end
	endtask

	// strobes rise and fall on falling edges, so the rising edge sees them settled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge clock);
		regWrEn = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge clock);
		regRdEn = 1'b0;
		d = regRdData;
	endtask

	task automatic checkReset();
		for (int i = 0; i < 12; i++) begin
			rd(8'h18 + 8'(i), rdVal);
			check("reset readback", {30'h0, rstVals[i]}, {30'h0, rdVal});
		end
		check("reset outputs", {3'h4, 4'h4, 4'h0, 1'h1, 1'h0, 1'h0, 8'h00, 1'h0, 1'h1, 1'h0,
			1'h0, 2'h0, 4'h3, 6'h00}, outs);
		$display("test reset values done");
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// the whole run is about 120 cycles; this leaves ample slack
	initial begin
		repeat (5000) @(posedge clock);
		badCount++;
		summarize();
	end

	initial begin
		rst_n = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		ldoShortDet = 1'b0;
		rstVals = '{8'h04, 8'h00, 8'h40, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h00, 8'h03,
			8'h00, 8'h00};
		rows = '{{ATR_OFS_OSC_BIAS, 8'hFF, 8'h07}, {ATR_OFS_RSVD_A, 8'hFF, 8'h00},
			{ATR_OFS_REF_TRIM, 8'hFF, 8'hFF}, {ATR_OFS_RSVD_B, 8'hFF, 8'h00},
			{ATR_OFS_PLL_CTRL, 8'hFF, 8'h13}, {ATR_OFS_PLL_CUR, 8'hA5, 8'hA5},
			{ATR_OFS_PLL_DET, 8'hFF, 8'h01}, {ATR_OFS_REG_SHORT, 8'hFF, 8'h11},
			{ATR_OFS_UV_TEST, 8'hFF, 8'h03}, {ATR_OFS_LINE_TEST, 8'hFF, 8'h0F},
			{ATR_OFS_PWR_OVR_A, 8'hFF, 8'h3F}, {8'h23, 8'hFF, 8'h00}};
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		checkReset();
		for (int i = 0; i < 12; i++) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rdVal);
			check("readback", {30'h0, rows[i][7:0]}, {30'h0, rdVal});
		end
		check("all set", {3'h7, 4'hF, 4'hF, 1'h1, 1'h1, 1'h1, 8'hA5, 1'h1, 1'h1, 1'h1, 1'h0,
			2'h3, 4'hF, 6'h3F}, outs);
		$display("test table done");
		// test mode off hides the current code at the pin but not on readback
		wr(ATR_OFS_PLL_CTRL, 8'h10);
		check("gated code", 38'h0, {30'h0, pllTestCurrentCode});
		rd(ATR_OFS_PLL_CUR, rdVal);
		check("stored code", 38'hA5, {30'h0, rdVal});
		wr(ATR_OFS_PLL_CTRL, 8'h02);
		check("divider hold", 38'h0, {37'h0, pllDividerReset_n});
		check("code in test", 38'hA5, {30'h0, pllTestCurrentCode});
		wr(ATR_OFS_PLL_CTRL, 8'h12);
		check("divider run", 38'h1, {37'h0, pllDividerReset_n});
		$display("test pll gating done");
		// short with auto power-down disabled, then enabled
		@(negedge clock);
		ldoShortDet = 1'b1;
		@(negedge clock);
		check("short flag", 38'h0, {36'h0, regulatorOk, ldoPowerDown});
		rd(ATR_OFS_REG_SHORT, rdVal);
		check("short read", 38'h01, {30'h0, rdVal});
		wr(ATR_OFS_REG_SHORT, 8'h00);
		@(negedge clock);
		check("auto off", 38'h1, {36'h0, regulatorOk, ldoPowerDown});
		ldoShortDet = 1'b0;
		repeat (2) @(negedge clock);
		check("short gone", 38'h2, {36'h0, regulatorOk, ldoPowerDown});
		$display("test regulator short done");
		// same-edge write and read returns the value held before the write
		@(negedge clock);
		regAddr = ATR_OFS_PWR_OVR_A;
		regWrData = 8'h15;
		regWrEn = 1'b1;
		regRdEn = 1'b1;
		@(negedge clock);
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		check("read old", 38'h3F, {30'h0, regRdData});
		check("override", 38'h15, {32'h0, powerOverride});
		$display("test write read collision done");
		// reset in mid-run must restore every field
		@(negedge clock);
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		checkReset();
		summarize();
	end
endmodule
